/* cet_defs.svh */
// Constants for the CCD exposure time controller: timing, offsets, fields, reset values
`ifndef CET_DEFS_SVH
`define CET_DEFS_SVH

// ==========================================================================
// Clock
`define CET_CLK_HZ          250000000
`define CET_CLK_NS          4

// ==========================================================================
// Line and field timing
`define CET_LINE_HZ         15750
`define CET_LINE_CYC        (`CET_CLK_HZ / `CET_LINE_HZ)
`define CET_HSYNC_NS        6000
`define CET_HSYNC_CYC       ((`CET_HSYNC_NS + `CET_CLK_NS - 1) / `CET_CLK_NS)
`define CET_FIELD_LINES     262
`define CET_VSYNC_LINES     3

// ==========================================================================
// Camera pulse and readout hold-off
`define CET_PULSE_US        200
`define CET_PULSE_CYC       ((`CET_PULSE_US * 1000 + `CET_CLK_NS - 1) / `CET_CLK_NS)
`define CET_HOLDOFF_MS      17
`define CET_HOLDOFF_CYC     ((`CET_HOLDOFF_MS * 1000000 + `CET_CLK_NS - 1) / `CET_CLK_NS)

// ==========================================================================
// Widths
`define CET_REF_W           14
`define CET_PIX_W           14
`define CET_LINE_W          9
`define CET_TMR_W           23
`define CET_CNT_W           8

// ==========================================================================
// Register offsets, fields, reset values
`define CET_OFS_CONTROL     4'h0
`define CET_OFS_HOST_EXP    4'h4
`define CET_OFS_STATUS      4'h8
`define CET_CTL_SRC_LSB     0
`define CET_STS_PHASE_LSB   0
`define CET_STS_HOLD_BIT    2
`define CET_STS_BTN_BIT     3
`define CET_STS_DONE_BIT    4
`define CET_STS_READS_LSB   8
`define CET_STS_LINES_LSB   16
`define CET_RST_SRC         2'h1
`define CET_RST_HOST_EXP    14'h041a
`define CET_MIN_REF         14'h0001

`endif

/* cet_pkg.sv */
// Types and shared functions of the CCD exposure time controller
package cet_pkg;
`include "cet_defs.svh"

	typedef enum logic [1:0] {
		CET_IDLE    = 2'b00,
		CET_ARMED   = 2'b01,
		CET_EXPOSE  = 2'b10,
		CET_HOLDOFF = 2'b11
	} cet_phase_type;

	typedef enum logic [1:0] {
		CET_SRC_EXT    = 2'b00,
		CET_SRC_HOST   = 2'b01,
		CET_SRC_MANUAL = 2'b10
	} cet_src_type;

	typedef struct packed {
		cet_phase_type               phase;
		logic [`CET_PIX_W-1:0]       pix;
		logic [`CET_LINE_W-1:0]      line;
		logic [`CET_REF_W-1:0]       lines;
		logic                        done;
		logic                        hsync;
		logic                        vsync;
		logic                        grab_trigger;
		cet_src_type                 src;
		logic [`CET_REF_W-1:0]       host_ref;
		logic [`CET_CNT_W-1:0]       readouts;
		logic                        waitreq;
		logic [31:0]                 readdata;
	} cet_top_state_type;

	typedef struct packed {
		logic [`CET_TMR_W-1:0]       cnt;
		logic                        pulse_n;
	} cet_pulse_state_type;

	// ==========================================================================
	// Byte-enable merge of a write into a register word
	function automatic logic [31:0] cet_be_merge(
		input logic [31:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Zero exposure would fire read on the very next line; floor it
	function automatic logic [`CET_REF_W-1:0] cet_ref_floor(input logic [`CET_REF_W-1:0] v);
		return (v < `CET_MIN_REF) ? `CET_MIN_REF : v;
	endfunction

endpackage

/* cet_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module cet_pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output var  logic [WIDTH-1:0] sync_out
);
	import cet_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] o;
	} cet_sync_state_type;

	cet_sync_state_type q;
	cet_sync_state_type d;

	// ==========================================================================
	// Only s2 reads s1; the filter looks at s2 and s3
	always_comb begin
		d = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3) begin
			d.o = q.s3;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.o;

endmodule
`default_nettype wire

/* cet_pulse_timer.sv */
// Retriggerable-free one-shot counting system clock cycles, active-low output
`timescale 1ns/1ns
`default_nettype none

`include "cet_defs.svh"

module cet_pulse_timer #(
	parameter int LEN = 1
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic fire,
	input  wire logic abort,
	output var  logic pulse_n
);
	import cet_pkg::*;

	localparam logic [`CET_TMR_W-1:0] LAST = `CET_TMR_W'(LEN - 1);

	cet_pulse_state_type q;
	cet_pulse_state_type d;

	// ==========================================================================
	// Abort beats fire; fire while running is ignored so widths never stretch
	always_comb begin
		d = q;
		if (abort) begin
			d.pulse_n = 1'b1;
			d.cnt = '0;
		end else if (q.pulse_n) begin
			if (fire) begin
				d.pulse_n = 1'b0;
				d.cnt = LAST;
			end
		end else if (q.cnt == '0) begin
			d.pulse_n = 1'b1;
		end else begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '{cnt: '0, pulse_n: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign pulse_n = q.pulse_n;

endmodule
`default_nettype wire

/* cet_exposure_ctrl.sv */
// Top of the CCD exposure time controller: sync generation, exposure sequencing, host port
//
// What the document requires
// R01: Exposure is the span from clear pulse to read pulse, both aligned to hsync.
// R02: Camera empties sensor on clear and sends blank fields until read.
// R03: Camera restarts a field with the image on read, then blanks again.
// R04: Read pulse starts together with both vertical and horizontal sync.
// R05: Next clear pulse comes in the first blank field after the readout field; the 17 ms holdoff outlasts the 262-line field, so it comes in the second.
// R06: Horizontal sync about 6 us wide at about 15750 Hz, brought out.
// R07: Vertical sync is the horizontal sync train divided by 262, own output.
// R08: Host computer can supply the exposure reference.
// R09: Reference comes from external input, host, or manual setting by select.
// R10: From idle a rising vsync arms; next hsync fires the clear pulse.
// R11: Clear sets exposure phase, disarms, blocks hsyncs and starts the timer.
// R12: Timer reaching reference gates next hsync out as read; back to idle.
// R13: After read, arming is held off about 17 ms across the readout field.
// R14: Frame grabber trigger follows the exposure phase state.
// R15: First read forces field alignment; later reads stay synchronised.
// R16: Held reset button clears phase and arming and suppresses camera pulses.
// R17: Camera treats the next pulse as read after a one-second reset hold.
// R18: Exposure timer covers 1 to 1000 ms.
// R19: Grabber acquires only on the trigger from this controller.
// R20: Exposure timer is a counter of lines compared with a programmed count.
// R21: Pulse widths come from counting system clock cycles.
// R22: Reset button is synchronised to the system clock before use.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

`include "cet_defs.svh"

module cet_exposure_ctrl
	import cet_pkg::*;
#(
	parameter int LINE_CYC    = `CET_LINE_CYC,
	parameter int PULSE_CYC   = `CET_PULSE_CYC,
	parameter int HOLDOFF_CYC = `CET_HOLDOFF_CYC
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  reset_button,
	input  wire logic [`CET_REF_W-1:0] ext_exposure,
	input  wire logic [`CET_REF_W-1:0] manual_exposure,
	input  wire logic [3:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output var  logic [31:0]           avs_readdata,
	output var  logic                  avs_waitrequest,
	output var  logic                  hsync,
	output var  logic                  vsync,
	output var  logic                  cam_pulse_n,
	output var  logic                  grab_trigger
);
	import cet_pkg::*;

	localparam logic [`CET_PIX_W-1:0]  PIX_LAST   = `CET_PIX_W'(LINE_CYC - 1);
	localparam logic [`CET_PIX_W-1:0]  HSYNC_CYC  = `CET_PIX_W'(`CET_HSYNC_CYC);
	localparam logic [`CET_LINE_W-1:0] LINE_LAST  = `CET_LINE_W'(`CET_FIELD_LINES - 1);
	localparam logic [`CET_LINE_W-1:0] VSYNC_LNS  = `CET_LINE_W'(`CET_VSYNC_LINES);
	localparam logic [`CET_REF_W-1:0]  LINES_MAX  = '1;

	localparam cet_top_state_type TOP_RESET = '{
		phase:        CET_IDLE,
		pix:          '0,
		line:         '0,
		lines:        '0,
		done:         1'b0,
		hsync:        1'b0,
		vsync:        1'b0,
		grab_trigger: 1'b0,
		src:          cet_src_type'(`CET_RST_SRC),
		host_ref:     `CET_RST_HOST_EXP,
		readouts:     '0,
		waitreq:      1'b1,
		readdata:     '0
	};

	cet_top_state_type         q;
	cet_top_state_type         d;

	logic                      btn;
	logic [`CET_REF_W-1:0]     ext_sync;
	logic [`CET_REF_W-1:0]     manual_sync;
	logic                      pulse_busy_n;
	logic                      holdoff_n;

	logic                      line_start;
	logic                      pix_last;
	logic [`CET_LINE_W-1:0]    line_eff;
	logic [`CET_REF_W-1:0]     ref_sel;
	logic [`CET_REF_W-1:0]     ref_now;
	logic                      arm_state;
	logic                      exposure_phase_state;
	logic                      line_gate_enable;
	logic                      line_sync_gate;
	logic                      clear_fire;
	logic                      read_fire;
	logic                      holdoff_combine;
	logic                      arm_clear_combine;
	logic                      vsync_rise;
	logic                      bus_req;
	logic                      addr_ok;
	logic [31:0]               rd_val;
	logic [31:0]               ctl_word;
	logic [31:0]               exp_word;
	logic [31:0]               merged;

	// ==========================================================================
	// Pin synchronisers
	cet_pin_sync #(
		.WIDTH (1)
	) reset_button_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.pin_in   (reset_button),
		.sync_out (btn)
	); // [R22]

	// A multi-bit level only moves once s2 and s3 agree, so a torn sample never reaches the compare
	cet_pin_sync #(
		.WIDTH (`CET_REF_W)
	) ext_exposure_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.pin_in   (ext_exposure),
		.sync_out (ext_sync)
	);

	cet_pin_sync #(
		.WIDTH (`CET_REF_W)
	) manual_exposure_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.pin_in   (manual_exposure),
		.sync_out (manual_sync)
	);

	// ==========================================================================
	// Pulse generators
	cet_pulse_timer #(
		.LEN (PULSE_CYC)
	) camera_pulse_generator (
		.sys_clk (sys_clk),
		.rst     (rst),
		.fire    (clear_fire | read_fire),
		.abort   (btn),
		.pulse_n (pulse_busy_n)
	); // [R01] [R21] [R16]

	cet_pulse_timer #(
		.LEN (HOLDOFF_CYC)
	) readout_holdoff_pulse (
		.sys_clk (sys_clk),
		.rst     (rst),
		.fire    (read_fire),
		.abort   (btn),
		.pulse_n (holdoff_n)
	); // [R13]

	// ==========================================================================
	// Next-state logic
	always_comb begin
		d = q;

		// Reference source select
		case (q.src)
			CET_SRC_EXT: begin
				ref_sel = ext_sync;
			end
			CET_SRC_HOST: begin
				ref_sel = q.host_ref; // [R08]
			end
			default: begin
				ref_sel = manual_sync;
			end
		endcase // [R09]
		ref_now = cet_ref_floor(ref_sel); // [R18]

		// Line and field counters
		line_start = (q.pix == '0);
		pix_last = (q.pix == PIX_LAST);
		d.pix = pix_last ? '0 : q.pix + 1'b1; // [R06]
		if (pix_last) begin
			d.line = (q.line == LINE_LAST) ? '0 : q.line + 1'b1; // [R07]
		end

		// Gating network
		arm_state = (q.phase == CET_ARMED);
		exposure_phase_state = (q.phase == CET_EXPOSE);
		line_gate_enable = arm_state | (exposure_phase_state & q.done);
		line_sync_gate = line_start & line_gate_enable & ~btn;
		clear_fire = line_sync_gate & arm_state; // [R10]
		read_fire = line_sync_gate & exposure_phase_state; // [R12]
		holdoff_combine = exposure_phase_state | ~holdoff_n | (q.phase == CET_HOLDOFF);
		arm_clear_combine = holdoff_combine | btn;

		// A read restarts the field so it lands on the start of vsync
		line_eff = read_fire ? '0 : q.line; // [R04] [R15]
		if (read_fire) begin
			d.line = '0;
		end
		vsync_rise = line_start & (line_eff == '0);

		// Outputs lag the counters one cycle, same as the pulse generator
		d.hsync = (q.pix < HSYNC_CYC); // [R06]
		d.vsync = (line_eff < VSYNC_LNS); // [R07]

		// Line-count exposure timer
		d.done = exposure_phase_state & (q.lines >= ref_now) & pulse_busy_n; // [R20]
		if (clear_fire) begin
			d.lines = '0; // [R11]
		end else if (exposure_phase_state & line_start & ~q.done & (q.lines != LINES_MAX)) begin
			d.lines = q.lines + 1'b1; // [R20]
		end

		// Sequencer
		case (q.phase)
			CET_IDLE: begin
				if (vsync_rise & ~arm_clear_combine) begin
					d.phase = CET_ARMED; // [R10] [R05]
				end
			end
			CET_ARMED: begin
				if (clear_fire) begin
					d.phase = CET_EXPOSE; // [R11]
				end
			end
			CET_EXPOSE: begin
				if (read_fire) begin
					d.phase = CET_HOLDOFF; // [R12]
					d.done = 1'b0;
					d.readouts = q.readouts + 1'b1;
				end
			end
			CET_HOLDOFF: begin
				if (holdoff_n) begin
					d.phase = CET_IDLE; // [R13]
				end
			end
			default: begin
				d.phase = CET_IDLE;
			end
		endcase
		if (btn) begin
			d.phase = CET_IDLE; // [R16]
			d.done = 1'b0;
		end
		d.grab_trigger = (d.phase == CET_EXPOSE); // [R14]

		// Register words
		ctl_word = '0;
		ctl_word[`CET_CTL_SRC_LSB +: 2] = q.src;
		exp_word = '0;
		exp_word[`CET_REF_W-1:0] = q.host_ref;
		addr_ok = (avs_address[1:0] == 2'h0);
		case (avs_address)
			`CET_OFS_CONTROL: begin
				rd_val = ctl_word;
			end
			`CET_OFS_HOST_EXP: begin
				rd_val = exp_word;
			end
			`CET_OFS_STATUS: begin
				rd_val = '0;
				rd_val[`CET_STS_PHASE_LSB +: 2] = q.phase;
				rd_val[`CET_STS_HOLD_BIT] = ~holdoff_n;
				rd_val[`CET_STS_BTN_BIT] = btn;
				rd_val[`CET_STS_DONE_BIT] = q.done;
				rd_val[`CET_STS_READS_LSB +: `CET_CNT_W] = q.readouts;
				rd_val[`CET_STS_LINES_LSB +: `CET_REF_W] = q.lines;
			end
			default: begin
				rd_val = '0;
			end
		endcase
		if (!addr_ok) begin
			rd_val = '0;
		end

		// Avalon slave: one wait cycle, write commits on the released edge
		bus_req = avs_read | avs_write;
		merged = '0;
		if (bus_req & q.waitreq) begin
			d.waitreq = 1'b0;
			d.readdata = avs_read ? rd_val : '0;
		end else if (bus_req) begin
			d.waitreq = 1'b1;
			if (avs_write & addr_ok) begin
				case (avs_address)
					`CET_OFS_CONTROL: begin
						merged = cet_be_merge(ctl_word, avs_writedata, avs_byteenable);
						d.src = cet_src_type'(merged[`CET_CTL_SRC_LSB +: 2]); // [R09]
					end
					`CET_OFS_HOST_EXP: begin
						merged = cet_be_merge(exp_word, avs_writedata, avs_byteenable);
						d.host_ref = merged[`CET_REF_W-1:0]; // [R08]
					end
					default: begin
						merged = '0;
					end
				endcase
			end
		end else begin
			d.waitreq = 1'b1;
		end
	end

	// ==========================================================================
	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= TOP_RESET;
		end else begin
			q <= d;
		end
	end

	assign avs_readdata    = q.readdata;
	assign avs_waitrequest = q.waitreq;
	assign hsync           = q.hsync;
	assign vsync           = q.vsync;
	assign cam_pulse_n     = pulse_busy_n; // [R01]
	assign grab_trigger    = q.grab_trigger;

endmodule
`default_nettype wire

/* cet_exposure_ctrl_asserts.sv */
// Port assertions of the exposure controller
`timescale 1ns/1ns
`default_nettype none

module cet_exposure_ctrl_asserts #(
	parameter int LINE_CYC  = 2000,
	parameter int PULSE_CYC = 100
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reset_button,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic cam_pulse_n,
	input wire logic grab_trigger
);
	// ==========================================================
	// Counters; widths far beyond any span seen
	logic [31:0] per_q, hi_q, vs_q, lo_q;
	logic        hs_q, seen_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			per_q <= '0;
			hi_q <= '0;
			vs_q <= '0;
			lo_q <= '0;
			hs_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			per_q <= (hsync & ~hs_q) ? 32'h0000_0001 : per_q + 1;
			hi_q <= hsync ? hi_q + 1 : '0;
			vs_q <= vsync ? vs_q + 1 : '0;
			lo_q <= cam_pulse_n ? '0 : lo_q + 1;
			hs_q <= hsync;
			seen_q <= seen_q | (hsync & ~hs_q);
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_hs_width; $fell(hsync) |-> hi_q == 32'h0000_05dc; endproperty
	a_hs_width: assert property (p_hs_width) else $error("hsync width wrong");
	property p_hs_period; hsync && !hs_q && seen_q |-> per_q == LINE_CYC; endproperty
	a_hs_period: assert property (p_hs_period) else $error("hsync period wrong");
	property p_vs_on_hs; $rose(vsync) |-> $rose(hsync); endproperty
	a_vs_on_hs: assert property (p_vs_on_hs) else $error("vsync off line start");
	property p_vs_width; $fell(vsync) |-> vs_q == 3 * LINE_CYC; endproperty
	a_vs_width: assert property (p_vs_width) else $error("vsync width wrong");
	property p_clear;
		$fell(cam_pulse_n) && !$past(grab_trigger) |-> $rose(hsync) && grab_trigger;
	endproperty
	a_clear: assert property (p_clear) else $error("clear pulse misplaced");
	property p_read;
		$fell(cam_pulse_n) && $past(grab_trigger) |-> $rose(vsync) && $rose(hsync) && !grab_trigger;
	endproperty
	a_read: assert property (p_read) else $error("read pulse misplaced");
	property p_pulse_width; $rose(cam_pulse_n) && !reset_button |-> lo_q == PULSE_CYC; endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
	property p_button; reset_button [*8] |-> cam_pulse_n && !grab_trigger; endproperty
	a_button: assert property (p_button) else $error("pulse not suppressed");
	property p_bus;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer wrong");
endmodule

bind cet_exposure_ctrl cet_exposure_ctrl_asserts #(
	.LINE_CYC  (LINE_CYC),
	.PULSE_CYC (PULSE_CYC)
) u_cet_exposure_ctrl_asserts (
	.sys_clk         (sys_clk),
	.rst             (rst),
	.reset_button    (reset_button),
	.avs_read        (avs_read),
	.avs_write       (avs_write),
	.avs_waitrequest (avs_waitrequest),
	.hsync           (hsync),
	.vsync           (vsync),
	.cam_pulse_n     (cam_pulse_n),
	.grab_trigger    (grab_trigger)
);

`default_nettype wire

/* cet_camera_model.sv */
// Behavioural camera and grabber seen from the controller's pulse side
`timescale 1ns/1ns
`default_nettype none

module cet_camera_model #(
	parameter int HOLD_CYC = 500
) (
	input  wire logic       sys_clk,
	input  wire logic       reset_button,
	input  wire logic       cam_pulse_n,
	input  wire logic       grab_trigger,
	output var  logic [7:0] read_count,
	output var  logic [7:0] grab_count,
	output var  logic       next_read
);
	logic        cam_q = 1'b1;
	logic        grab_q = 1'b0;
	logic [31:0] hold_q = '0;
	logic [7:0]  reads_q = '0;
	logic [7:0]  grabs_q = '0;
	logic        next_q = 1'b0;
	assign read_count = reads_q;
	assign grab_count = grabs_q;
	assign next_read  = next_q;
	// Leading edge only: the camera ignores pulse width
	always @(posedge sys_clk) begin
		cam_q <= cam_pulse_n;
		grab_q <= grab_trigger;
		hold_q <= reset_button ? hold_q + 1 : '0;
		if (hold_q == HOLD_CYC) begin
			next_q <= 1'b1;
		end else if (cam_q && !cam_pulse_n) begin
			next_q <= !next_q;
			if (next_q) begin
				reads_q <= reads_q + 8'h01;
			end
		end
		if (grab_q && !grab_trigger) begin
			grabs_q <= grabs_q + 8'h01;
		end
	end
endmodule

`default_nettype wire

/* cet_exposure_ctrl_tb_top.sv */
// Testbench of the exposure controller
`timescale 1ns/1ns
`default_nettype none

`include "cet_defs.svh"

module cet_exposure_ctrl_tb_top;
	import cet_pkg::*;
	localparam int LC = 2000;
	localparam int PC = 100;
	localparam int HC = 3000;
	logic                  sys_clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  reset_button = 1'b0;
	logic [`CET_REF_W-1:0] ext_exposure = 14'h0003;
	logic [`CET_REF_W-1:0] manual_exposure = 14'h0005;
	logic [3:0]            avs_address = 4'h0;
	logic                  avs_read = 1'b0;
	logic                  avs_write = 1'b0;
	logic [31:0]           avs_writedata = '0;
	logic [3:0]            avs_byteenable = 4'hf;
	logic [31:0]           avs_readdata;
	logic                  avs_waitrequest, hsync, vsync, cam_pulse_n, grab_trigger;
	logic [7:0]            read_count, grab_count;
	logic                  next_read, cam_q = 1'b1;
	int                    err_count = 0, tests_run = 0, cyc = 0, falls = 0, t_fall = 0;

	cet_exposure_ctrl #(.LINE_CYC(LC), .PULSE_CYC(PC), .HOLDOFF_CYC(HC)) u_cet_exposure_ctrl (
		.sys_clk(sys_clk), .rst(rst), .reset_button(reset_button),
		.ext_exposure(ext_exposure), .manual_exposure(manual_exposure),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.hsync(hsync), .vsync(vsync), .cam_pulse_n(cam_pulse_n), .grab_trigger(grab_trigger)
	);
	cet_camera_model #(.HOLD_CYC(500)) u_cet_camera_model (
		.sys_clk(sys_clk), .reset_button(reset_button), .cam_pulse_n(cam_pulse_n),
		.grab_trigger(grab_trigger), .read_count(read_count), .grab_count(grab_count),
		.next_read(next_read)
	);

	// ==========================================================
	// Clock, pulse edge log and hang limit
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		cam_q <= cam_pulse_n;
		if (cam_q && !cam_pulse_n) begin
			falls <= falls + 1;
			t_fall <= cyc;
		end
		if (cyc == 100000) begin
			err_count++;
			end_sim();
		end
	end

	// ==========================================================
	// Tasks
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Request starts after an edge and is held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge sys_clk);
			n++;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk("bus wait", 32'h0000_0001, 32'(n));
	endtask
	task automatic wait_falls(input int tgt, input int lim);
		int n;
		n = 0;
		while (falls < tgt && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		chk("pulse count", 32'(tgt), 32'(falls));
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
	endtask

	// ==========================================================
	// Sequence: one exposure per source code, then the hold button
	initial begin
		logic [31:0] rd;
		int          base, tc, lines;
		for (int i = 0; i < 4; i++) begin
			do_reset();
			if (i == 0) begin
				bus(1'b0, 4'h0, '0, 4'hf, rd);
				chk("control reset", 32'h0000_0001, rd);
				bus(1'b0, 4'h4, '0, 4'hf, rd);
				chk("host reset", 32'h0000_041a, rd);
				bus(1'b1, 4'h4, 32'h0000_ff00, 4'h2, rd);
				bus(1'b0, 4'h4, '0, 4'hf, rd);
				chk("host lane", 32'h0000_3f1a, rd);
				bus(1'b1, 4'h1, 32'h0000_0002, 4'hf, rd);
				bus(1'b0, 4'h0, '0, 4'hf, rd);
				chk("unmapped write", 32'h0000_0001, rd);
				bus(1'b0, 4'hc, '0, 4'hf, rd);
				chk("unmapped read", 32'h0000_0000, rd);
			end
			bus(1'b1, 4'h4, 32'h0000_0004, 4'hf, rd);
			bus(1'b1, 4'h0, 32'(i), 4'hf, rd);
			lines = (i == 0) ? 3 : (i == 1) ? 4 : 5;
			base = falls;
			wait_falls(base + 1, 2 * LC);
			tc = t_fall;
			wait_falls(base + 2, (lines + 3) * LC);
			chk("exposure", 32'((lines + 1) * LC), 32'(t_fall - tc));
			chk("vsync at read", 32'h0000_0001, {31'h0, vsync});
			chk("trigger at read", 32'h0000_0000, {31'h0, grab_trigger});
			bus(1'b0, 4'h8, '0, 4'hf, rd);
			chk("holdoff", (32'(lines) << 16) | 32'h0000_0107, rd);
			repeat (HC + LC) @(posedge sys_clk);
			bus(1'b0, 4'h8, '0, 4'hf, rd);
			chk("idle", 32'h0000_0000, rd & 32'h0000_0007);
			chk("no early clear", 32'(base + 2), 32'(falls));
			chk("camera reads", 32'(i + 1), {24'h0, read_count});
			chk("grabbed", 32'(i + 1), {24'h0, grab_count});
			$display("test %0d done", i);
		end
		do_reset();
		reset_button <= 1'b1;
		repeat (600) @(posedge sys_clk);
		chk("camera read armed", 32'h0000_0001, {31'h0, next_read});
		reset_button <= 1'b0;
		do_reset();
		base = falls;
		wait_falls(base + 1, 2 * LC);
		repeat (20) @(posedge sys_clk);
		reset_button <= 1'b1;
		repeat (3 * LC) @(posedge sys_clk);
		chk("suppressed", 32'(base + 1), 32'(falls));
		chk("pulse idle", 32'h0000_0001, {31'h0, cam_pulse_n});
		chk("trigger low", 32'h0000_0000, {31'h0, grab_trigger});
		bus(1'b0, 4'h8, '0, 4'hf, rd);
		chk("button status", 32'h0000_0008, rd & 32'h0000_000f);
		chk("camera read next", 32'h0000_0001, {31'h0, next_read});
		reset_button <= 1'b0;
		$display("test button done");
		end_sim();
	end
endmodule

`default_nettype wire
